/* File: lamp_starter_sequencer.sv */
/*
  Control sequencer of a fluorescent lamp starter: lockout, preheat,
  strike, lamp-state check with retries, standby supply regulation.
  Assumes comparator inputs are synchronous to clk and the analog
  switch, clamp and divider sit outside.
*/
// Overview of operation
// - Hold sequencer reset while supply too low
// - Static select input picks preheat length
// - First preheat lengths per variant and frequency
// - Power switch fully on throughout preheat
// - Preheat timed by counting whole mains cycles
// - Retry preheats last half the first
// - Switch off when current reaches threshold
// - Eight off cycles start a shorter retry
// - Eight failed attempts stop until supply reset
// - Lit lamp going off restarts fresh sequence
// - Standby closes supply switch below low level
// - Standby opens supply switch at high level
// - Preheat charges supply at half cycle edges
// - Lamp state from divided voltage comparison
// - Sample lamp state at mains peak
module lamp_starter_sequencer
  import lamp_pkg::*;
#(
  parameter int PEAK_CYC = PEAK_DELAY_CYC,
  parameter int SHORT_CYC = PREHEAT_SHORT_CYC,
  parameter int LONG_CYC = PREHEAT_LONG_CYC,
  parameter int OFF_CYC = OFF_CYCLES,
  parameter int ATTEMPTS = MAX_ATTEMPTS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic low_supply_lockout,
  input wire logic preheat_sel,
  input wire logic mains_pos,
  input wire logic current_at_threshold,
  input wire logic lamp_above_level,
  input wire logic vcc_below_low,
  input wire logic vcc_at_high,
  output logic bidirectional_power_switch,
  output logic supply_switch,
  output logic lamp_lit,
  output logic starter_stopped,
  output logic [CNT_W-1:0] attempt_count
);
  localparam logic [PREHEAT_W-1:0] SHORT_LEN = PREHEAT_W'(SHORT_CYC);
  localparam logic [PREHEAT_W-1:0] LONG_LEN = PREHEAT_W'(LONG_CYC);
  localparam logic [CNT_W-1:0] OFF_LIM = CNT_W'(OFF_CYC);
  localparam logic [CNT_W-1:0] ATT_LIM = CNT_W'(ATTEMPTS);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [PREHEAT_W-1:0] PH_ONE = PREHEAT_W'(1);

  //////////////////////////////////////////////////////////////////////
  // Reset release and timebase

  logic rst_m_r;
  logic rst_sync_b;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_sync_b <= rst_m_r;
    end
  end

  mains_tb_if tb ();

  mains_timebase #(
    .PEAK_CYC(PEAK_CYC)
  ) u_timebase (
    .clk(clk),
    .rst_sync_b(rst_sync_b),
    .clk_en(clk_en),
    .mains_pos(mains_pos),
    .tb(tb)
  );

  //////////////////////////////////////////////////////////////////////
  // Sequencer

  seq_state_t state_r;
  seq_state_t state_nxt;
  logic first_r;
  logic [PREHEAT_W-1:0] ph_cnt_r;
  logic [CNT_W-1:0] off_cnt_r;
  logic [CNT_W-1:0] att_r;
  logic sw_r;
  logic sup_r;

  // Lamp off shows near full mains at the divider, lit about 80 V
  wire lamp_off = lamp_above_level;
  // Only the positive peak counts, so one sample per mains cycle
  wire sample = tb.peak_strobe & tb.pos_half;
  wire [PREHEAT_W-1:0] first_len = preheat_sel ? LONG_LEN : SHORT_LEN;
  // Retries use the halved count of the same select
  wire [PREHEAT_W-1:0] ph_len =
    first_r ? first_len : (first_len >> 1);
  wire ph_done = tb.cycle_tick && (ph_cnt_r + PH_ONE >= ph_len);
  wire off_full = sample && lamp_off && (off_cnt_r + CNT_ONE >= OFF_LIM);
  wire att_left = (att_r < ATT_LIM);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      st_lockout: state_nxt = st_preheat;
      st_preheat: if (ph_done) state_nxt = st_ignite;
      st_ignite: if (current_at_threshold) state_nxt = st_check;
      st_check: begin
        if (sample && !lamp_off) begin
          state_nxt = st_lit;
        end else if (off_full) begin
          state_nxt = att_left ? st_preheat : st_stopped;
        end
      end
      st_lit: if (off_full) state_nxt = st_preheat;
      st_stopped: state_nxt = st_stopped;
    endcase
  end

  // Lockout acts as a synchronous hold; state stays frozen with clk_en
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_r <= st_lockout;
    end else if (clk_en) begin
      state_r <= low_supply_lockout ? st_lockout : state_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ph_cnt_r <= '0;
    end else if (clk_en) begin
      if (state_r != st_preheat || ph_done) begin
        ph_cnt_r <= '0;
      end else if (tb.cycle_tick) begin
        ph_cnt_r <= ph_cnt_r + PH_ONE;
      end
    end
  end

  // Off run counter; any lit sample breaks the run
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      off_cnt_r <= '0;
    end else if (clk_en) begin
      if ((state_r != st_check && state_r != st_lit) || off_full) begin
        off_cnt_r <= '0;
      end else if (sample) begin
        off_cnt_r <= lamp_off ? off_cnt_r + CNT_ONE : '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      att_r <= '0;
      first_r <= 1'b1;
    end else if (clk_en) begin
      if (low_supply_lockout || (state_r == st_lit && off_full)) begin
        att_r <= '0;
        first_r <= 1'b1;
      end else if (state_r == st_ignite && current_at_threshold) begin
        att_r <= att_r + CNT_ONE;
        first_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Switch drive and supply regulation

  wire sw_nxt = (state_nxt == st_preheat) || (state_nxt == st_ignite);
  wire in_lit = (state_r == st_lit);
  // Standby charging; close wins if both comparators fire at a half cycle start
  wire sup_lit = (tb.half_start && vcc_below_low) ? 1'b1 :
                 vcc_at_high ? 1'b0 : sup_r;
  // Charging pulse is one clock; the analog stage stretches it
  wire sup_ph = tb.half_start | tb.half_end;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sw_r <= 1'b0;
      sup_r <= 1'b0;
    end else if (clk_en) begin
      sw_r <= low_supply_lockout ? 1'b0 : sw_nxt;
      sup_r <= (in_lit && !low_supply_lockout) ? sup_lit :
               (state_r == st_preheat) ? (sup_ph & tb.pos_half | tb.half_start)
                                       : 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      lamp_lit <= 1'b0;
      starter_stopped <= 1'b0;
      attempt_count <= '0;
    end else if (clk_en) begin
      lamp_lit <= (state_nxt == st_lit) && !low_supply_lockout;
      starter_stopped <= (state_nxt == st_stopped) && !low_supply_lockout;
      // Lockout clears the visible count at once, not one cycle late
      attempt_count <= low_supply_lockout ? '0 : att_r;
    end
  end

  assign bidirectional_power_switch = sw_r;
  assign supply_switch = sup_r;
endmodule : lamp_starter_sequencer

/* File: lamp_pkg.sv */
/*
  Shared constants for the lamp starter sequencer: clock rate, mains
  timebase, preheat lengths, lamp-off check and attempt limits.
  Assumes a 50 MHz system clock and a 50 Hz mains for the defaults.
*/
package lamp_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int MAINS_HZ = 50;
  // Peak of the mains wave after a zero crossing, in microseconds
  localparam int PEAK_DELAY_US = 5000;
  localparam int PEAK_DELAY_CYC = PEAK_DELAY_US * (CLK_HZ / 1_000_000);
  // First preheat lengths in milliseconds, converted to mains cycles
  localparam int PREHEAT_SHORT_MS = 1500;
  localparam int PREHEAT_LONG_MS = 2560;
  localparam int PREHEAT_SHORT_CYC = PREHEAT_SHORT_MS * MAINS_HZ / 1000;
  localparam int PREHEAT_LONG_CYC = PREHEAT_LONG_MS * MAINS_HZ / 1000;
  localparam int PREHEAT_W = 8;
  // Consecutive off cycles that declare a failed strike
  localparam int OFF_CYCLES = 8;
  localparam int MAX_ATTEMPTS = 8;
  localparam int CNT_W = 4;

  typedef enum logic [2:0] {
    st_lockout,
    st_preheat,
    st_ignite,
    st_check,
    st_lit,
    st_stopped
  } seq_state_t;
endpackage : lamp_pkg

/* File: mains_tb_if.sv */
/*
  Mains timebase bundle between the timebase and the sequencer.
  Assumes all strobes are one clock wide and synchronous to clk.
*/
interface mains_tb_if;
  logic cycle_tick;
  logic half_start;
  logic half_end;
  logic peak_strobe;
  logic pos_half;
  modport src (output cycle_tick, half_start, half_end, peak_strobe,
               pos_half);
  modport snk (input cycle_tick, half_start, half_end, peak_strobe,
               pos_half);
endinterface : mains_tb_if

/* File: mains_timebase.sv */
/*
  Mains timebase: zero-crossing edges of the sensed mains polarity give
  a cycle tick, half cycle start and end strobes and a peak strobe.
  Assumes mains_pos is synchronous and already free of chatter.
*/
module mains_timebase
  import lamp_pkg::*;
#(
  parameter int PEAK_CYC = PEAK_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst_sync_b,
  input wire logic clk_en,
  input wire logic mains_pos,
  mains_tb_if.src tb
);
  localparam int PW = $clog2(PEAK_CYC + 1);
  localparam logic [PW-1:0] PEAK_LOAD = PW'(PEAK_CYC);
  localparam logic [PW-1:0] ONE = PW'(1);

  logic prev_r;
  logic [PW-1:0] peak_cnt_r;
  logic [PW-1:0] peak_cnt_nxt;
  wire rise = mains_pos & ~prev_r;
  wire fall = ~mains_pos & prev_r;
  wire peak_hit = (peak_cnt_r == ONE);

  // Each zero crossing restarts the peak delay
  assign peak_cnt_nxt = (rise | fall) ? PEAK_LOAD :
                        (peak_cnt_r != '0) ? peak_cnt_r - ONE : peak_cnt_r;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      prev_r <= 1'b0;
      peak_cnt_r <= '0;
    end else if (clk_en) begin
      prev_r <= mains_pos;
      peak_cnt_r <= peak_cnt_nxt;
    end
  end

  // One tick per mains cycle, on the rising zero crossing
  assign tb.cycle_tick = rise & clk_en;
  assign tb.half_start = rise & clk_en;
  assign tb.half_end = fall & clk_en;
  assign tb.peak_strobe = peak_hit & clk_en;
  assign tb.pos_half = prev_r;
endmodule : mains_timebase

/* File: lamp_starter_sequencer_properties.sv */
/* Port checker of the lamp starter sequencer.
   Assumes a bind to the top module and one clock domain. */
module lamp_seq_props
  import lamp_pkg::*;
#(parameter int ATTEMPTS = MAX_ATTEMPTS) (
  input wire logic clk, rst_b, clk_en, low_supply_lockout, mains_pos,
  input wire logic current_at_threshold, vcc_below_low, vcc_at_high,
  input wire logic bidirectional_power_switch, supply_switch, lamp_lit,
  input wire logic starter_stopped,
  input wire logic [CNT_W-1:0] attempt_count
);
  timeunit 1ns;
  timeprecision 1ns;
  wire sw = bidirectional_power_switch;
  wire lk = low_supply_lockout;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////
  a_lockout_clear: assert property (lk && clk_en |=> !sw &&
    !supply_switch && !lamp_lit && !starter_stopped && attempt_count == 4'h0)
    else $error("lockout left an output set");
  a_off_at_thresh: assert property ($fell(sw) && !$past(lk) |->
    $past(current_at_threshold)) else $error("switch off without current");
  a_count_step: assert property ($fell(sw) && !lk && !$past(lk) |=>
    attempt_count == $past(attempt_count) + 4'h1) else $error("no count");
  a_count_moves: assert property ($changed(attempt_count) |->
    attempt_count == 4'h0 || attempt_count == $past(attempt_count) + 4'h1)
    else $error("attempt count jumped");
  a_stop_count: assert property ($rose(starter_stopped) |->
    attempt_count == ATTEMPTS) else $error("stopped too early");
  a_stop_holds: assert property (starter_stopped && !lk |=>
    starter_stopped && !sw && !lamp_lit) else $error("stop not held");
  a_supply_opens: assert property (lamp_lit && vcc_at_high &&
    !vcc_below_low |=> !supply_switch || !lamp_lit) else $error("no open");
  a_supply_closes: assert property (lamp_lit && vcc_below_low &&
    $rose(mains_pos) |-> ##[1:4] supply_switch) else $error("no close");
endmodule : lamp_seq_props

bind lamp_starter_sequencer lamp_seq_props #(.ATTEMPTS(ATTEMPTS))
  u_props (.*);

/* File: lamp_partner.sv */
/* Far side model: mains wave, ballast current and the lamp itself.
   Assumes one clock; the bench decides if the lamp can strike. */
module lamp_partner #(parameter int HALF = 40) (
  input wire logic clk, sw, lamp_good,
  output logic mains_pos, cur_hit, lamp_off
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph = 0;
  logic lit = 1'b0;
  logic sw_q = 1'b0;
  initial mains_pos = 1'b0;
  always begin
    @(posedge clk);
    #1;
    ph = (ph + 1) % HALF;
    if (ph == 0) mains_pos = !mains_pos;
    if (!lamp_good) lit = 1'b0;
    else if (sw_q && !sw) lit = 1'b1;
    sw_q = sw;
  end
  // Current only reaches switch-off level in the positive half
  assign cur_hit = sw && mains_pos;
  assign lamp_off = !lit;
endmodule : lamp_partner

/* File: lamp_starter_sequencer_tb.sv */
/* Self-checking bench of the lamp starter sequencer and lamp model.
   Assumes shortened mains timing through the design parameters. */
module lamp_starter_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SHORT = 4;
  localparam int LONG = 6;
  logic clk = 0, rst_b = 0, lk = 0, sel = 0, good = 1, vlow = 0, vhi = 0;
  wire sw, mains, cur, loff, sup, lit, stop;
  wire [3:0] cnt;
  wire [3:0] fl = {sw, sup, lit, stop};
  int err_total = 0;
  int samples_checked = 0;
  always #10 clk = !clk;
  lamp_partner pm (.clk(clk), .sw(sw), .lamp_good(good),
    .mains_pos(mains), .cur_hit(cur), .lamp_off(loff));
  lamp_starter_sequencer #(.PEAK_CYC(20), .SHORT_CYC(SHORT),
    .LONG_CYC(LONG)) dut (.clk(clk), .rst_b(rst_b), .clk_en(1'b1),
    .low_supply_lockout(lk), .preheat_sel(sel), .mains_pos(mains),
    .current_at_threshold(cur), .lamp_above_level(loff),
    .vcc_below_low(vlow), .vcc_at_high(vhi),
    .bidirectional_power_switch(sw), .supply_switch(sup),
    .lamp_lit(lit), .starter_stopped(stop), .attempt_count(cnt));
  ////////////////////////////////
  task automatic chk(input string w, input logic [3:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", w, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Bounded wait, flags are {switch, supply, lit, stopped}
  task automatic settle(input logic [3:0] e);
    for (int i = 0; i < 2000 && fl !== e; i++) tick(1);
    chk("flags", e, fl);
  endtask
  // Mains rises seen while the switch stays on
  task automatic preheat(input int len, input int att);
    int n;
    n = 0;
    wait (sw === 1'b1);
    while (sw === 1'b1) begin
      @(posedge mains or negedge sw);
      if (sw === 1'b1) n++;
    end
    // Count lags one edge, so it still shows this attempt's number
    #1;
    chk("attempts", 4'(att), cnt);
    chk("preheat", 4'(len), 4'(n));
  endtask
  task automatic t_first;
    preheat(SHORT, 0);
    settle(4'b0010);
    chk("attempts", 4'h1, cnt);
    $display("t_first done");
  endtask
  task automatic t_reg;
    vlow = 1;
    settle(4'b0110);
    vlow = 0;
    vhi = 1;
    tick(3);
    chk("flags", 4'b0010, fl);
    vhi = 0;
    $display("t_reg done");
  endtask
  task automatic t_retry;
    good = 0;
    preheat(SHORT, 0);
    for (int i = 1; i < 8; i++) preheat(SHORT / 2, i);
    settle(4'b0001);
    chk("attempts", 4'h8, cnt);
    tick(400);
    chk("flags", 4'b0001, fl);
    $display("t_retry done");
  endtask
  task automatic t_lock;
    lk = 1;
    tick(3);
    chk("flags", 4'h0, fl);
    chk("attempts", 4'h0, cnt);
    sel = 1;
    good = 1;
    tick(200);
    chk("flags", 4'h0, fl);
    lk = 0;
    preheat(LONG, 0);
    settle(4'b0010);
    $display("t_lock done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    tick(10);
    rst_b = 1;
    t_first;
    t_reg;
    t_retry;
    t_lock;
    results;
  end
  // Whole run is near 8000 cycles
  initial begin
    #1_500_000;
    err_total++;
    results;
  end
endmodule : lamp_starter_sequencer_tb
